// *** hdl/icache_consts.vh ***
`ifndef ICACHE_CONSTS_VH
`define ICACHE_CONSTS_VH

// Geometry
`define IC_SETS 16
`define IC_ENTRIES 32
`define IC_SET_BITS 4
`define IC_ADDR_BITS 24
`define IC_TAG_BITS 20
`define IC_INSTR_BITS 48

// APB register byte offsets
`define IC_OFF_MODE 8'h00
`define IC_OFF_STATUS 8'h04
`define IC_OFF_COUNT 8'h08

// Mode register field positions and reset value
`define IC_CACHE_OFF_POS 4
`define IC_EXT_OFF_POS 6
`define IC_HOLD_POS 19
`define IC_MODE_RESET 32'h0000_0000
`define IC_MODE_MASK 32'h0008_0050

// Status register field positions
`define IC_ST_OFF_POS 0
`define IC_ST_EXT_OFF_POS 1
`define IC_ST_HOLD_POS 2
`define IC_ST_FLUSH_POS 3
`define IC_ST_NVALID_LO 8

// Latencies in cycles
`define IC_FLUSH_INT_LAT 1
`define IC_FLUSH_EXT_LAT 2
`define IC_HOLD_LAT 2

`endif

// *** hdl/cache_set_match.v ***
`timescale 1ns/10ps
`include "icache_consts.vh"

// Compares one address tag against both entries of a set.
module cache_set_match (
  input wire [`IC_TAG_BITS-1:0] tag0,
  input wire [`IC_TAG_BITS-1:0] tag1,
  input wire valid0,
  input wire valid1,
  input wire [`IC_TAG_BITS-1:0] tag,
  output wire hit,
  output wire way
);
  wire match0;
  wire match1;

  assign match0 = valid0 && (tag0 == tag);
  assign match1 = valid1 && (tag1 == tag);
  assign hit = match0 | match1;
  // Both valid and equal cannot arise because fills only happen on a miss
  assign way = match1;
endmodule

// *** hdl/instruction_cache_control.v ***
// How it works
// - Invalidate-all clears valid bits regardless of disable
// - Invalidate latency: one internal, two external
// - Reset clears all LRU and valid bits
// - Freeze takes effect two instructions later
// - Bit 4 set turns the cache off
// - Disabled cache keeps contents, reports no hits
// - Bit 6 stops caching of external fetches only
// - Bit 19 freezes contents; misses store nothing
// - Disabled: conflicting internal fetches are delayed
// - Per-set LRU picks the replaced entry
// - 32 entries, 16 sets, four-bit index
// - Miss fills LRU entry and flips LRU
// - Internal lookup on conflict only; external always
//
// The APB register port and the address map are this design's own decisions.
`timescale 1ns/10ps
`include "icache_consts.vh"

module instruction_cache_control (
  input wire clk,
  input wire resetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output wire [31:0] prdata,
  output wire pready,
  output wire pslverr,
  input wire flushReq,
  input wire flushExt,
  input wire fetchValid,
  input wire [`IC_ADDR_BITS-1:0] fetchAddr,
  input wire fetchExt,
  input wire pmdConflict,
  input wire [`IC_INSTR_BITS-1:0] memInstr,
  output wire fetchStall,
  output wire lookupHit,
  output wire decodeValid,
  output wire [`IC_INSTR_BITS-1:0] decodeInstr,
  output wire decodeFromCache
);

  localparam SB = `IC_SET_BITS;
  localparam TB = `IC_TAG_BITS;
  localparam IB = `IC_INSTR_BITS;

  // Entry index: way in the top bit, set in the low bits
  function [SB:0] entryIdx;
    input way;
    input [SB-1:0] set;
    begin
      entryIdx = {way, set};
    end
  endfunction

  function isMapped;
    input [7:0] addr;
    begin
      isMapped = (addr == `IC_OFF_MODE) || (addr == `IC_OFF_STATUS) ||
        (addr == `IC_OFF_COUNT);
    end
  endfunction

  // Storage; contents have no reset, only valid and LRU do
  reg [TB-1:0] tagMem [0:`IC_ENTRIES-1];
  reg [IB-1:0] dataMem [0:`IC_ENTRIES-1];
  // Valid and LRU bits live in the per-set flops of g_set
  wire [`IC_ENTRIES-1:0] validVec;
  wire [`IC_SETS-1:0] lruVec;

  // Mode register (second_mode_register)
  reg [31:0] mode_r;
  // Second freeze latency stage; mode_r itself is the first
  reg holdPipe_r;
  reg [31:0] prdata_r;
  reg [15:0] hitCnt_r;
  reg [15:0] missCnt_r;

  // Invalidate latency pipe
  reg flushInt_r;
  reg flushExt1_r;
  reg flushExt2_r;

  // Fetch2 stage
  reg f2Valid_r;
  reg f2Hit_r;
  reg f2Fill_r;
  reg f2Bypass_r;
  reg f2Way_r;
  reg [`IC_ADDR_BITS-1:0] f2Addr_r;
  reg [IB-1:0] f2Data_r;

  // Decode stage outputs and the load bus
  reg decValid_r;
  reg decFromCache_r;
  reg [IB-1:0] decInstr_r;
  reg [IB-1:0] loadInstr_r;

  wire cacheOffBit;
  wire externalCacheOffBit;
  wire cacheHoldBit;
  wire holdEff;
  wire [SB-1:0] fetchSet;
  wire [TB-1:0] fetchTag;
  wire lookupReq;
  wire arrayHit;
  wire arrayWay;
  wire bypassHit;
  wire hitNow;
  wire fillNow;
  wire fillWay;
  wire doFlush;
  wire [SB-1:0] f2Set;
  wire [TB-1:0] f2Tag;
  wire [SB:0] fillIdx;
  wire apbWrite;
  wire apbSetup;
  reg [5:0] validCount;
  integer k;

  assign cacheOffBit = mode_r[`IC_CACHE_OFF_POS];
  assign externalCacheOffBit = mode_r[`IC_EXT_OFF_POS];
  assign cacheHoldBit = mode_r[`IC_HOLD_POS];
  // A lookup two edges after the mode write is the first one frozen
  assign holdEff = holdPipe_r;

  assign fetchSet = fetchAddr[SB-1:0];
  assign fetchTag = fetchAddr[`IC_ADDR_BITS-1:SB];
  assign f2Set = f2Addr_r[SB-1:0];
  assign f2Tag = f2Addr_r[`IC_ADDR_BITS-1:SB];

  // Lookup only on conflict internally, every fetch externally
  assign lookupReq = fetchValid && !cacheOffBit &&
    (fetchExt ? !externalCacheOffBit : pmdConflict);

  cache_set_match u_match (
    .tag0(tagMem[entryIdx(1'b0, fetchSet)]),
    .tag1(tagMem[entryIdx(1'b1, fetchSet)]),
    .valid0(validVec[entryIdx(1'b0, fetchSet)]),
    .valid1(validVec[entryIdx(1'b1, fetchSet)]),
    .tag(fetchTag),
    .hit(arrayHit),
    .way(arrayWay)
  );

  // A miss one cycle ahead to the same address is not in the array yet
  assign bypassHit = lookupReq && f2Valid_r && f2Fill_r && (f2Addr_r == fetchAddr);
  assign hitNow = lookupReq && (arrayHit || bypassHit);
  assign fillNow = lookupReq && !hitNow && !holdEff;
  assign fillWay = lruVec[fetchSet];
  assign lookupHit = hitNow;

  // Disabled cache cannot absorb the conflict, so the fetch waits
  assign fetchStall = fetchValid && !fetchExt && pmdConflict && cacheOffBit;

  assign doFlush = flushInt_r || flushExt2_r;
  assign fillIdx = entryIdx(f2Way_r, f2Set);

  // Invalidate latency pipe
  // External execution needs one more stage before the valid bits clear
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      flushInt_r <= 1'b0;
      flushExt1_r <= 1'b0;
      flushExt2_r <= 1'b0;
    end else begin
      flushInt_r <= flushReq && !flushExt;
      flushExt1_r <= flushReq && flushExt;
      flushExt2_r <= flushExt1_r;
    end
  end

  // Valid and LRU per set; a fill landing with a flush still sets its entry
  genvar s;
  generate
    for (s = 0; s < `IC_SETS; s = s + 1) begin : g_set
      localparam [SB-1:0] SETID = s;
      reg way0Valid_r;
      reg way1Valid_r;
      reg setLru_r;
      wire fillHere;
      wire lookHere;

      assign fillHere = f2Valid_r && f2Fill_r && (f2Set == SETID);
      assign lookHere = lookupReq && (fetchSet == SETID);
      assign validVec[s] = way0Valid_r;
      assign validVec[s + `IC_SETS] = way1Valid_r;
      assign lruVec[s] = setLru_r;

      always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
          way0Valid_r <= 1'b0;
          way1Valid_r <= 1'b0;
          setLru_r <= 1'b0;
        end else begin
          if (fillHere) begin
            // Set wins: the filled way stays valid even under a flush
            way0Valid_r <= !f2Way_r || (way0Valid_r && !doFlush);
            way1Valid_r <= f2Way_r || (way1Valid_r && !doFlush);
          end else if (doFlush) begin
            // Flush ignores the disable bit and spares LRU and contents
            way0Valid_r <= 1'b0;
            way1Valid_r <= 1'b0;
          end
          if (lookHere) begin
            if (hitNow && !bypassHit) begin
              setLru_r <= !arrayWay;
            end else if (fillNow) begin
              setLru_r <= !fillWay;
            end
          end
        end
      end
    end
  endgenerate

  // Array write in the decode stage with the instruction from memory
  always @(posedge clk) begin
    if (f2Valid_r && f2Fill_r) begin
      tagMem[fillIdx] <= f2Tag;
      dataMem[fillIdx] <= memInstr;
    end
  end

  // Fetch1 to Fetch2
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      f2Valid_r <= 1'b0;
      f2Hit_r <= 1'b0;
      f2Fill_r <= 1'b0;
      f2Bypass_r <= 1'b0;
      f2Way_r <= 1'b0;
      f2Addr_r <= {`IC_ADDR_BITS{1'b0}};
      f2Data_r <= {IB{1'b0}};
    end else begin
      f2Valid_r <= fetchValid && !fetchStall;
      f2Hit_r <= hitNow;
      f2Fill_r <= fillNow;
      f2Bypass_r <= bypassHit;
      f2Way_r <= fillNow ? fillWay : arrayWay;
      f2Addr_r <= fetchAddr;
      f2Data_r <= dataMem[entryIdx(arrayWay, fetchSet)];
    end
  end

  // Fetch2 to Decode: memory data on a miss, cache or load bus on a hit
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      decValid_r <= 1'b0;
      decFromCache_r <= 1'b0;
      decInstr_r <= {IB{1'b0}};
      loadInstr_r <= {IB{1'b0}};
    end else begin
      decValid_r <= f2Valid_r;
      decFromCache_r <= f2Valid_r && f2Hit_r;
      if (f2Hit_r) begin
        decInstr_r <= f2Bypass_r ? loadInstr_r : f2Data_r;
      end else begin
        decInstr_r <= memInstr;
      end
      if (f2Valid_r && f2Fill_r) begin
        loadInstr_r <= memInstr;
      end
    end
  end

  assign decodeValid = decValid_r;
  assign decodeInstr = decInstr_r;
  assign decodeFromCache = decFromCache_r;

  // APB slave: zero wait states, read data captured in the setup phase
  assign apbSetup = psel && !penable;
  assign apbWrite = psel && penable && pwrite && isMapped(paddr);
  assign pready = psel && penable;
  assign pslverr = psel && penable && !isMapped(paddr);
  assign prdata = prdata_r;

  // Population count of the valid bits for the status register
  always @* begin
    validCount = 6'h00;
    for (k = 0; k < `IC_ENTRIES; k = k + 1) begin
      validCount = validCount + {5'h00, validVec[k]};
    end
  end

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      mode_r <= `IC_MODE_RESET;
      holdPipe_r <= 1'b0;
    end else begin
      if (apbWrite && (paddr == `IC_OFF_MODE)) begin
        // Off bits take effect on the next fetch, the freeze bit one fetch later; software leaves the gap cycle
        mode_r <= pwdata & `IC_MODE_MASK;
      end
      holdPipe_r <= cacheHoldBit;
    end
  end

  // Counters saturate so software sees a stable ratio after long runs
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      hitCnt_r <= 16'h0000;
      missCnt_r <= 16'h0000;
    end else if (apbWrite && (paddr == `IC_OFF_COUNT)) begin
      hitCnt_r <= 16'h0000;
      missCnt_r <= 16'h0000;
    end else if (lookupReq) begin
      if (hitNow && (hitCnt_r != 16'hffff)) begin
        hitCnt_r <= hitCnt_r + 16'h0001;
      end else if (!hitNow && (missCnt_r != 16'hffff)) begin
        missCnt_r <= missCnt_r + 16'h0001;
      end
    end
  end

  // Read data is latched in the setup phase, so the access needs no wait
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      prdata_r <= 32'h0000_0000;
    end else if (apbSetup) begin
      case (paddr)
        `IC_OFF_MODE: prdata_r <= mode_r;
        `IC_OFF_STATUS: begin
          prdata_r <= 32'h0000_0000;
          prdata_r[`IC_ST_OFF_POS] <= cacheOffBit;
          prdata_r[`IC_ST_EXT_OFF_POS] <= externalCacheOffBit;
          prdata_r[`IC_ST_HOLD_POS] <= holdEff;
          prdata_r[`IC_ST_FLUSH_POS] <= flushExt1_r || doFlush;
          prdata_r[`IC_ST_NVALID_LO+5:`IC_ST_NVALID_LO] <= validCount;
        end
        `IC_OFF_COUNT: prdata_r <= {hitCnt_r, missCnt_r};
        default: prdata_r <= 32'h0000_0000;
      endcase
    end
  end

  // The instruction after an invalidate carries no PM data access

endmodule

// *** dv/pmem_model.sv ***
`timescale 1ns/10ps
module pmem_model (
  input wire logic clk,
  input wire logic fetchValid,
  input wire logic fetchStall,
  input wire logic [23:0] fetchAddr,
  output logic [47:0] memInstr
);
  initial memInstr = '0;
  // Outside Fetch2 the bus flips every cycle so a stale word never looks valid
  always @(posedge clk) begin
    if (fetchValid && !fetchStall)
      memInstr <= {fetchAddr ^ 24'ha5a5a5, fetchAddr};
    else
      memInstr <= ~memInstr;
  end
endmodule

// *** dv/icache_checker_sva.sv ***
`timescale 1ns/10ps
module icache_checker (
  input wire logic clk,
  input wire logic resetn,
  input wire logic fetchValid,
  input wire logic fetchExt,
  input wire logic pmdConflict,
  input wire logic [47:0] memInstr,
  input wire logic fetchStall,
  input wire logic lookupHit,
  input wire logic decodeValid,
  input wire logic [47:0] decodeInstr,
  input wire logic decodeFromCache
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  wire taken = fetchValid && !fetchStall;
  a_stall_cause: assert property (fetchStall |-> fetchValid && !fetchExt && pmdConflict)
    else $error("stall without an internal conflicting fetch");
  a_stall_nohit: assert property (fetchStall |-> !lookupHit)
    else $error("hit shown while stalled");
  a_stall_drop: assert property (fetchStall |-> ##2 !decodeValid)
    else $error("stalled fetch reached decode");
  a_decode_lat: assert property (taken |-> ##2 decodeValid)
    else $error("fetch not delivered two cycles later");
  a_decode_cause: assert property (decodeValid |-> $past(taken, 2))
    else $error("decode without a fetch");
  a_hit_lookup: assert property (lookupHit |-> fetchValid && (fetchExt || pmdConflict))
    else $error("hit without a lookup");
  a_hit_source: assert property (taken && lookupHit |-> ##2 decodeFromCache)
    else $error("hit not served from cache");
  a_miss_memory: assert property (taken && !lookupHit |=> ##1
    !decodeFromCache && decodeInstr == $past(memInstr))
    else $error("miss not served from memory");
  c_hit: cover property (taken && lookupHit);
  c_stall: cover property (fetchStall);
  c_ext_hit: cover property (lookupHit && fetchExt);
  c_load_bus: cover property ((taken && !lookupHit) ##1 (taken && lookupHit));
endmodule
bind instruction_cache_control icache_checker i_icache_checker (.*);

// *** dv/tb.sv ***
`timescale 1ns/10ps
`include "icache_consts.vh"
module tb;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic [31:0] prdata, rd;
  logic pready, pslverr, err, fetchStall, lookupHit, decodeValid, decodeFromCache;
  logic flushReq = 1'b0;
  logic flushExt = 1'b0;
  logic fetchValid = 1'b0;
  logic fetchExt = 1'b0;
  logic pmdConflict = 1'b0;
  logic [23:0] fetchAddr = '0;
  logic [47:0] memInstr, decodeInstr;
  logic [23:0] lruA [6] = '{24'h5, 24'h15, 24'h5, 24'h25, 24'h5, 24'h15};
  logic lruH [6] = '{1'b0, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0};
  int failures = 0;
  int comparisons = 0;
  int cyc = 0;
  instruction_cache_control i_instruction_cache_control (.*);
  pmem_model i_pmem_model (.*);
  initial forever #5 clk = ~clk;
  task automatic close_out();
    $display("failures %0d comparisons %0d", failures, comparisons);
    if (failures == 0 && comparisons > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      failures++;
      close_out();
    end
  end
  task automatic chk(input logic [49:0] got, input logic [49:0] exp);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("FAIL %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic setMode(input logic [31:0] d);
    apb(1'b1, `IC_OFF_MODE, d);
    @(posedge clk);
  endtask
  // m holds external, conflict and expected hit
  task automatic fetch(input logic [23:0] a, input logic [2:0] m);
    @(posedge clk);
    fetchValid <= 1'b1;
    fetchAddr <= a;
    fetchExt <= m[2];
    pmdConflict <= m[1];
    @(negedge clk);
    chk(lookupHit, m[0]);
    @(posedge clk);
    fetchValid <= 1'b0;
    pmdConflict <= 1'b0;
    @(posedge clk);
    @(negedge clk);
    chk({decodeValid, decodeFromCache, decodeInstr}, {1'b1, m[0], a ^ 24'ha5a5a5, a});
  endtask
  // Two back-to-back internal conflicting fetches; h holds both expected hits
  task automatic burst(input logic [23:0] a0, input logic [23:0] a1, input logic [1:0] h);
    fetchValid <= 1'b1;
    fetchExt <= 1'b0;
    pmdConflict <= 1'b1;
    fetchAddr <= a0;
    @(negedge clk);
    chk(lookupHit, h[1]);
    @(posedge clk);
    fetchAddr <= a1;
    @(negedge clk);
    chk(lookupHit, h[0]);
    @(posedge clk);
    fetchValid <= 1'b0;
    pmdConflict <= 1'b0;
    @(negedge clk);
    chk({decodeValid, decodeFromCache, decodeInstr}, {1'b1, h[1], a0 ^ 24'ha5a5a5, a0});
    @(negedge clk);
    chk({decodeValid, decodeFromCache, decodeInstr}, {1'b1, h[0], a1 ^ 24'ha5a5a5, a1});
  endtask
  task automatic flush(input logic e);
    @(posedge clk);
    flushReq <= 1'b1;
    flushExt <= e;
    @(posedge clk);
    flushReq <= 1'b0;
  endtask
  initial begin
    repeat (6) @(posedge clk);
    resetn <= 1'b1;
    apb(1'b0, `IC_OFF_MODE, '0);
    chk(rd, `IC_MODE_RESET);
    apb(1'b0, `IC_OFF_STATUS, '0);
    chk(rd[13:8], '0);
    apb(1'b0, 8'h10, '0);
    chk({err, rd}, {1'b1, 32'h0});
    fetch(24'h13, 3'b010);
    fetch(24'h13, 3'b011);
    fetch(24'h13, 3'b000);
    fetch(24'h100, 3'b100);
    fetch(24'h100, 3'b101);
    foreach (lruA[k]) fetch(lruA[k], {2'b01, lruH[k]});
    setMode(32'h10);
    fetch(24'h5, 3'b100);
    @(posedge clk);
    fetchValid <= 1'b1;
    fetchAddr <= 24'h5;
    fetchExt <= 1'b0;
    pmdConflict <= 1'b1;
    @(negedge clk);
    chk({fetchStall, lookupHit}, 2'b10);
    @(posedge clk);
    fetchValid <= 1'b0;
    pmdConflict <= 1'b0;
    setMode('0);
    fetch(24'h5, 3'b011);
    setMode(32'h40);
    apb(1'b0, `IC_OFF_STATUS, '0);
    chk(rd[3:0], 4'h2);
    fetch(24'h100, 3'b100);
    fetch(24'h5, 3'b011);
    fetch(24'h207, 3'b100);
    setMode('0);
    fetch(24'h207, 3'b100);
    apb(1'b1, `IC_OFF_MODE, 32'h80000);
    burst(24'ha, 24'hb, 2'b00);
    fetch(24'ha, 3'b011);
    fetch(24'hb, 3'b010);
    fetch(24'h9, 3'b010);
    fetch(24'h9, 3'b010);
    fetch(24'h207, 3'b101);
    setMode('0);
    flush(1'b0);
    @(posedge clk);
    fetch(24'h5, 3'b010);
    fetch(24'h5, 3'b011);
    @(posedge clk);
    burst(24'h3c, 24'h3c, 2'b01);
    setMode(32'h10);
    flush(1'b0);
    setMode('0);
    fetch(24'h5, 3'b010);
    fetch(24'h100, 3'b100);
    flush(1'b1);
    fetch(24'h100, 3'b101);
    fetch(24'h100, 3'b100);
    flush(1'b0);
    fetch(24'h100, 3'b100);
    apb(1'b1, `IC_OFF_MODE, 32'h40);
    resetn <= 1'b0;
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    apb(1'b0, `IC_OFF_MODE, '0);
    chk(rd, `IC_MODE_RESET);
    apb(1'b0, `IC_OFF_STATUS, '0);
    chk(rd, 32'h0);
    fetch(24'h100, 3'b100);
    fetch(24'h100, 3'b101);
    apb(1'b0, `IC_OFF_COUNT, '0);
    chk(rd, 32'h0001_0001);
    close_out();
  end
endmodule
